// ### src/scfl_defines.svh
`ifndef SCFL_DEFINES_SVH
`define SCFL_DEFINES_SVH
// Operation
// [R1] Indicator default polarity follows its latched strap
// [R2] Strap 0 gives active-high indicator, polarity 1
// [R3] Strap 1 gives active-low indicator, polarity 0
// [R4] Broadcast strap 0: answer address 0 too
// [R5] Broadcast strap 1: answer own address only
// [R6] Broadcast enable default is complemented strap
// [R7] Latch five-bit device mode at reset
// [R8] Interface strap: 0 full MAC, 1 reduced-pin
// [R9] Clock strap: 0 disables, 1 enables reference clock
// [R10] Style strap: 0 tri-colour, 1 individual indicators
// [R11] Capture straps on release of chip reset
// [R12] Own address is latched five-bit address strap
// [R13] Latched values hold until next reset release

// ----------------------------------------------------------------
// Widths and strap vector layout
// ----------------------------------------------------------------
`define SCFL_IND_COUNT 5
`define SCFL_MODE_W 5
`define SCFL_ADDR_W 5
`define SCFL_STRAP_W 19
`define SCFL_POS_IND 0
`define SCFL_POS_BCAST 5
`define SCFL_POS_MODE 6
`define SCFL_POS_IFSEL 11
`define SCFL_POS_CLKEN 12
`define SCFL_POS_STYLE 13
`define SCFL_POS_ADDR 14

// ----------------------------------------------------------------
// Timing: edges after reset release before straps are taken
// ----------------------------------------------------------------
`define SCFL_CAPTURE_DELAY 2'h2

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCFL_OFS_STRAP_STATUS 8'h00
`define SCFL_OFS_IND_POLARITY 8'h04
`define SCFL_OFS_BCAST_ENABLE 8'h08
`define SCFL_OFS_ACTIVE_CFG 8'h0c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SCFL_STAT_VALID_BIT 31
`define SCFL_CFG_IFSEL_BIT 0
`define SCFL_CFG_CLKEN_BIT 1
`define SCFL_CFG_STYLE_BIT 2
`define SCFL_CFG_MODE_LSB 8
`define SCFL_CFG_ADDR_LSB 16
`define SCFL_RST_POLARITY 5'h00
`define SCFL_RST_BCAST 1'h0
`define SCFL_RST_STRAPS 19'h00000

`endif

// ### src/scfl_pkg.sv
package scfl_pkg;

  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    SCFL_BUS_IDLE = 2'b01,
    SCFL_BUS_RDWAIT = 2'b10
  } scfl_bus_state_type;

  // Meaning of the interface-select strap
  typedef enum logic {
    SCFL_IF_FULL = 1'b0,
    SCFL_IF_REDUCED = 1'b1
  } scfl_if_sel_type;

endpackage

// ### src/scfl_strap_config_latch.sv
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "scfl_defines.svh"

module scfl_strap_config_latch
  import scfl_pkg::*;
(
  // Clock and chip reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Strap pins, asynchronous to hclk
  input wire logic [4:0] indicator_polarity_strap,
  input wire logic broadcast_address_strap,
  input wire logic [4:0] device_mode_strap,
  input wire logic interface_select_strap,
  input wire logic ref_clock_out_enable,
  input wire logic indicator_style_strap,
  input wire logic [4:0] station_address_strap,
  // Management address check
  input wire logic [4:0] mgmt_addr,
  output logic mgmt_addr_hit,
  // Configuration results
  output logic strap_valid,
  output logic [4:0] indicator_polarity,
  output logic broadcast_enable,
  output logic [4:0] device_mode,
  output logic reduced_pin_if,
  output logic ref_clock_out_pin_en,
  output logic indicator_individual,
  output logic [4:0] station_address
);

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  logic [`SCFL_STRAP_W-1:0] strap_pins;
  logic [`SCFL_STRAP_W-1:0] strap_meta_ff;
  logic [`SCFL_STRAP_W-1:0] strap_sync_ff;

  // Field order follows the strap vector layout in the defines
  assign strap_pins = {station_address_strap, indicator_style_strap, ref_clock_out_enable,
                       interface_select_strap, device_mode_strap, broadcast_address_strap,
                       indicator_polarity_strap};

  // Pins are board levels, so two stages before anything looks at them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_meta_ff <= `SCFL_RST_STRAPS;
      strap_sync_ff <= `SCFL_RST_STRAPS;
    end else begin
      strap_meta_ff <= strap_pins;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Capture at reset release
  // ----------------------------------------------------------------
  logic [1:0] cap_cnt_ff;
  logic [1:0] nxt_cap_cnt;
  logic strap_valid_ff;
  logic cap_wait_done;
  logic capture;
  logic [`SCFL_STRAP_W-1:0] strap_ff;

  // Wait until the synchroniser holds post-release levels
  assign cap_wait_done = (cap_cnt_ff == `SCFL_CAPTURE_DELAY);
  assign capture = !strap_valid_ff && cap_wait_done; // [R11]
  assign nxt_cap_cnt = cap_cnt_ff + 2'h1;

  // Counter parks at the delay so capture cannot repeat
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_cnt_ff <= 2'h0;
    end else if (!cap_wait_done) begin
      cap_cnt_ff <= nxt_cap_cnt;
    end
  end

  // One capture per reset; nothing reloads until the next release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_valid_ff <= 1'b0;
      strap_ff <= `SCFL_RST_STRAPS;
    end else if (capture) begin
      strap_valid_ff <= 1'b1;
      strap_ff <= strap_sync_ff; // [R11] [R13]
    end
  end

  // ----------------------------------------------------------------
  // Strap field views
  // ----------------------------------------------------------------
  logic [4:0] lat_ind;
  logic lat_bcast;
  logic [4:0] lat_mode;
  logic lat_ifsel;
  logic lat_clken;
  logic lat_style;
  logic [4:0] lat_addr;
  logic [4:0] dflt_polarity;

  // Named slices of the latched vector; all stay put until reset
  assign lat_ind = strap_ff[`SCFL_POS_IND +: `SCFL_IND_COUNT];
  assign lat_bcast = strap_ff[`SCFL_POS_BCAST];
  assign lat_mode = strap_ff[`SCFL_POS_MODE +: `SCFL_MODE_W]; // [R7]
  assign lat_ifsel = strap_ff[`SCFL_POS_IFSEL];
  assign lat_clken = strap_ff[`SCFL_POS_CLKEN];
  assign lat_style = strap_ff[`SCFL_POS_STYLE];
  assign lat_addr = strap_ff[`SCFL_POS_ADDR +: `SCFL_ADDR_W]; // [R12]

  // Pulled low means indicator to ground, so drive it active high
  genvar gi;
  generate
    for (gi = 0; gi < `SCFL_IND_COUNT; gi = gi + 1) begin : g_pol
      assign dflt_polarity[gi] = ~strap_sync_ff[`SCFL_POS_IND + gi]; // [R1] [R2] [R3]
    end
  endgenerate

  scfl_if_sel_type if_sel;

  // Typed view keeps the interface strap sense in one place
  assign if_sel = scfl_if_sel_type'(lat_ifsel); // [R8]

  // ----------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------
  scfl_bus_state_type bus_state_ff;
  scfl_bus_state_type nxt_bus_state;
  logic addr_phase;
  logic wr_pend_ff;
  logic [7:0] addr_ff;

  // Only NONSEQ/SEQ while the bus is ready start a transfer
  assign addr_phase = hsel && hready && htrans[1];

  // Address and direction kept for the data phase; a stalled bus keeps them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so a write just ahead is already stored
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      SCFL_BUS_IDLE: begin
        if (addr_phase && !hwrite) begin
          nxt_bus_state = SCFL_BUS_RDWAIT;
        end
      end
      SCFL_BUS_RDWAIT: begin
        nxt_bus_state = SCFL_BUS_IDLE;
      end
      default: begin
        nxt_bus_state = SCFL_BUS_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_ff <= SCFL_BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // Only reads stall; every answer is OKAY
  assign hreadyout = (bus_state_ff != SCFL_BUS_RDWAIT);
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Software-visible control registers
  // ----------------------------------------------------------------
  logic [4:0] polarity_ff;
  logic bcast_en_ff;
  logic wr_commit;
  logic wr_polarity;
  logic wr_bcast;

  // Write data phase ends on this edge; hsize is word only, not checked
  assign wr_commit = wr_pend_ff && hreadyout;

  // One strobe per writable register; read-only offsets never strobe
  assign wr_polarity = wr_commit && (addr_ff == `SCFL_OFS_IND_POLARITY);
  assign wr_bcast = wr_commit && (addr_ff == `SCFL_OFS_BCAST_ENABLE);

  // Strap gives the default, software may override later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      polarity_ff <= `SCFL_RST_POLARITY;
    end else if (capture) begin
      polarity_ff <= dflt_polarity; // [R1]
    end else if (wr_polarity) begin
      polarity_ff <= hwdata[4:0];
    end
  end

  // Register bit has the opposite sense of the strap pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcast_en_ff <= `SCFL_RST_BCAST;
    end else if (capture) begin
      bcast_en_ff <= ~strap_sync_ff[`SCFL_POS_BCAST]; // [R6]
    end else if (wr_bcast) begin
      bcast_en_ff <= hwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] polarity_word;
  logic [31:0] bcast_word;
  logic [31:0] cfg_word;
  logic [31:0] rd_value;
  logic [31:0] hrdata_ff;

  // Latched strap vector with the capture flag on top
  always_comb begin
    status_word = 32'h00000000;
    status_word[`SCFL_POS_IND +: `SCFL_IND_COUNT] = lat_ind;
    status_word[`SCFL_POS_BCAST] = lat_bcast;
    status_word[`SCFL_POS_MODE +: `SCFL_MODE_W] = lat_mode;
    status_word[`SCFL_POS_IFSEL] = lat_ifsel;
    status_word[`SCFL_POS_CLKEN] = lat_clken;
    status_word[`SCFL_POS_STYLE] = lat_style;
    status_word[`SCFL_POS_ADDR +: `SCFL_ADDR_W] = lat_addr;
    status_word[`SCFL_STAT_VALID_BIT] = strap_valid_ff;
  end

  // Writable registers read back what software or the strap left there
  always_comb begin
    polarity_word = 32'h00000000;
    polarity_word[4:0] = polarity_ff;
    bcast_word = 32'h00000000;
    bcast_word[0] = bcast_en_ff;
  end

  // Settings in use, packed by function rather than by pin order
  always_comb begin
    cfg_word = 32'h00000000;
    cfg_word[`SCFL_CFG_IFSEL_BIT] = lat_ifsel;
    cfg_word[`SCFL_CFG_CLKEN_BIT] = lat_clken;
    cfg_word[`SCFL_CFG_STYLE_BIT] = lat_style;
    cfg_word[`SCFL_CFG_MODE_LSB +: `SCFL_MODE_W] = lat_mode;
    cfg_word[`SCFL_CFG_ADDR_LSB +: `SCFL_ADDR_W] = lat_addr;
  end

  // Offset select on the address kept from the address phase
  always_comb begin
    rd_value = 32'h00000000;
    case (addr_ff)
      `SCFL_OFS_STRAP_STATUS: begin
        rd_value = status_word;
      end
      `SCFL_OFS_IND_POLARITY: begin
        rd_value = polarity_word;
      end
      `SCFL_OFS_BCAST_ENABLE: begin
        rd_value = bcast_word;
      end
      `SCFL_OFS_ACTIVE_CFG: begin
        rd_value = cfg_word;
      end
      default: begin
        rd_value = 32'h00000000; // Unmapped reads as zero
      end
    endcase
  end

  // Loaded in the wait state, so a write just ahead is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (bus_state_ff == SCFL_BUS_RDWAIT) begin
      hrdata_ff <= rd_value;
    end
  end

  // Holds until the next read reloads it
  assign hrdata = hrdata_ff;

  // ----------------------------------------------------------------
  // Management address match
  // ----------------------------------------------------------------
  logic own_match;
  logic zero_match;
  logic hit_ff;

  // Own address always answers; address 0 only while broadcast is enabled
  assign own_match = (mgmt_addr == lat_addr); // [R5] [R12]
  assign zero_match = bcast_en_ff && (mgmt_addr == 5'h00); // [R4]

  // Registered so the answer is a clean level one cycle after mgmt_addr
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= strap_valid_ff && (own_match || zero_match);
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs, all flip-flop driven
  // ----------------------------------------------------------------
  // Bus-side status
  assign mgmt_addr_hit = hit_ff;
  assign strap_valid = strap_valid_ff;

  // Settings for the rest of the device
  assign indicator_polarity = polarity_ff; // [R2] [R3]
  assign broadcast_enable = bcast_en_ff;
  assign device_mode = lat_mode; // [R7]
  assign reduced_pin_if = (if_sel == SCFL_IF_REDUCED); // [R8]
  assign ref_clock_out_pin_en = lat_clken; // [R9]
  assign indicator_individual = lat_style; // [R10]
  assign station_address = lat_addr; // [R12]

endmodule

// ### test/scfl_strap_board.sv
`timescale 1ns/10ps

// Board resistors: one bit of pull_cfg per strap pin, 1 = pulled up
module scfl_strap_board (
  // Resistor pattern
  input wire logic [18:0] pull_cfg,
  // Strap pins
  output logic [4:0] ind,
  output logic bcast,
  output logic [4:0] mode,
  output logic ifsel,
  output logic clken,
  output logic style,
  output logic [4:0] addr
);
  // Pulls drive all the time; changing pull_cfg stands for a board rework
  assign {addr, style, clken, ifsel, mode, bcast, ind} = pull_cfg;
endmodule

// ### test/scfl_latch_assertions.sv
`timescale 1ns/10ps

module scfl_latch_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Strap pins and address check
  input wire logic [4:0] indicator_polarity_strap,
  input wire logic broadcast_address_strap,
  input wire logic [4:0] device_mode_strap,
  input wire logic interface_select_strap,
  input wire logic ref_clock_out_enable,
  input wire logic indicator_style_strap,
  input wire logic [4:0] station_address_strap,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_addr_hit,
  // Results
  input wire logic strap_valid,
  input wire logic [4:0] indicator_polarity,
  input wire logic broadcast_enable,
  input wire logic [4:0] device_mode,
  input wire logic reduced_pin_if,
  input wire logic ref_clock_out_pin_en,
  input wire logic indicator_individual,
  input wire logic [4:0] station_address
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Pins are held steady around capture, so they match the latch
  pol_default_a: assert property (
    $rose(strap_valid) |-> indicator_polarity == ~indicator_polarity_strap)
    else $error("polarity default");
  bcast_default_a: assert property (
    $rose(strap_valid) |-> broadcast_enable == !broadcast_address_strap)
    else $error("broadcast default");
  mode_addr_a: assert property (
    $rose(strap_valid) |-> device_mode == device_mode_strap
    && station_address == station_address_strap) else $error("mode or address");
  iface_flags_a: assert property (
    $rose(strap_valid) |-> {indicator_individual, ref_clock_out_pin_en, reduced_pin_if}
    == {indicator_style_strap, ref_clock_out_enable, interface_select_strap})
    else $error("flags");
  capture_time_a: assert property (
    $rose(hresetn) |-> !strap_valid ##[1:4] strap_valid) else $error("capture time");
  latch_hold_a: assert property (
    strap_valid && $past(strap_valid) |-> $stable(device_mode) && $stable(station_address)
    && $stable(reduced_pin_if) && $stable(indicator_individual)) else $error("hold");
  own_hit_a: assert property (
    strap_valid && mgmt_addr == station_address |=> mgmt_addr_hit) else $error("own hit");
  zero_hit_a: assert property (
    strap_valid && mgmt_addr == 5'h0 && broadcast_enable |=> mgmt_addr_hit)
    else $error("zero hit");
  no_hit_a: assert property (
    strap_valid && mgmt_addr != station_address && !(mgmt_addr == 5'h0 && broadcast_enable)
    |=> !mgmt_addr_hit) else $error("false hit");
endmodule

bind scfl_strap_config_latch scfl_latch_chk u_chk (.hclk, .hresetn,
  .indicator_polarity_strap, .broadcast_address_strap, .device_mode_strap,
  .interface_select_strap, .ref_clock_out_enable, .indicator_style_strap,
  .station_address_strap, .mgmt_addr, .mgmt_addr_hit, .strap_valid, .indicator_polarity,
  .broadcast_enable, .device_mode, .reduced_pin_if, .ref_clock_out_pin_en,
  .indicator_individual, .station_address);

// ### test/tb_strap_config_latch.sv
`timescale 1ns/10ps
`include "scfl_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module tb_strap_config_latch;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_s, hrdata;
  logic [4:0] mgmt_addr = 5'h0;
  logic [18:0] pull_cfg = 19'h0;
  logic hreadyout, hresp, mgmt_addr_hit, strap_valid, broadcast_enable, reduced_pin_if;
  logic ref_clock_out_pin_en, indicator_individual, p_bc, p_if, p_ck, p_st;
  logic [4:0] indicator_polarity, device_mode, station_address, p_ind, p_md, p_ad;
  int errors = 0, compares = 0, cycles = 0;

  // 250 MHz core clock
  always #2 hclk = ~hclk;

  scfl_strap_board board (.pull_cfg(pull_cfg), .ind(p_ind), .bcast(p_bc), .mode(p_md),
    .ifsel(p_if), .clken(p_ck), .style(p_st), .addr(p_ad));
  scfl_strap_config_latch dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .indicator_polarity_strap(p_ind), .broadcast_address_strap(p_bc),
    .device_mode_strap(p_md), .interface_select_strap(p_if), .ref_clock_out_enable(p_ck),
    .indicator_style_strap(p_st), .station_address_strap(p_ad), .mgmt_addr,
    .mgmt_addr_hit, .strap_valid, .indicator_polarity, .broadcast_enable, .device_mode,
    .reduced_pin_if, .ref_clock_out_pin_en, .indicator_individual, .station_address);

  task automatic summarize;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  // Ready and read data are both taken at the rising edge that ends the phase
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_s = hrdata;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask

  // Pins show the wrong pattern early in reset, so only release-time levels count
  task automatic do_reset(input logic [18:0] c);
    hresetn <= 1'b0;
    pull_cfg <= ~c;
    repeat (6) @(posedge hclk);
    pull_cfg <= c;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    while (strap_valid !== 1'b1) @(negedge hclk);
    @(posedge hclk);
  endtask

  task automatic t_straps(input logic [18:0] c);
    do_reset(c);
    `CHK(indicator_polarity, ~c[4:0])
    `CHK(broadcast_enable, ~c[5])
    `CHK(device_mode, c[10:6])
    `CHK({indicator_individual, ref_clock_out_pin_en, reduced_pin_if}, c[13:11])
    `CHK(station_address, c[18:14])
    `CHK({strap_valid, hresp}, 2'b10)
    bus(1'b0, `SCFL_OFS_STRAP_STATUS, 32'h0);
    `CHK(rd_s, {1'b1, 12'h0, c})
    bus(1'b0, `SCFL_OFS_ACTIVE_CFG, 32'h0);
    `CHK(rd_s, {11'h0, c[18:14], 3'h0, c[10:6], 5'h0, c[13:11]})
  endtask

  task automatic t_hold(input logic [18:0] c);
    pull_cfg <= ~c;
    repeat (20) @(posedge hclk);
    bus(1'b0, `SCFL_OFS_STRAP_STATUS, 32'h0);
    `CHK(rd_s, {1'b1, 12'h0, c})
    `CHK(device_mode, c[10:6])
  endtask

  task automatic t_mgmt(input logic [4:0] a, input logic e);
    mgmt_addr <= a;
    @(posedge hclk);
    @(negedge hclk);
    `CHK(mgmt_addr_hit, e)
    @(posedge hclk);
  endtask

  // Needs straps 2a5a5: own address 0a, broadcast strap 1
  task automatic t_regs;
    t_mgmt(5'h0, 1'b0);
    bus(1'b1, `SCFL_OFS_IND_POLARITY, 32'h15);
    bus(1'b0, `SCFL_OFS_IND_POLARITY, 32'h0);
    `CHK(rd_s, 32'h15)
    bus(1'b1, `SCFL_OFS_STRAP_STATUS, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd_s, 32'h0)
    bus(1'b0, `SCFL_OFS_STRAP_STATUS, 32'h0);
    `CHK(rd_s, 32'h8002a5a5)
    bus(1'b1, `SCFL_OFS_BCAST_ENABLE, 32'h1);
    t_mgmt(5'h0, 1'b1);
    t_mgmt(5'h0a, 1'b1);
    t_mgmt(5'h3, 1'b0);
  endtask

  initial begin
    t_straps(19'h7ffff);
    t_hold(19'h7ffff);
    t_straps(19'h00000);
    t_straps(19'h55a5a);
    t_straps(19'h2a5a5);
    t_regs();
    summarize();
  end
endmodule
